// ===== logic/ipe_defines.vh
// Behaviour
// - Every source owns a distinct event code, latched into the secondary code register.
// - All sources share one service entry; software branches on the latched code.
// - Programmable sources take levels 0 to 15 from five priority registers.
// - Reset clears every programmable priority level to zero.
// - Equal-level ties resolve by fixed order, non-maskable first, refresh overflow last.
// - Non-maskable input has fixed level 16 and code 0x1C0 in both registers.
// - Debug request has fixed level 15 and code 0x5E0 in both registers.
// - External, port, transfer, infrared, FIFO serial and converter primary codes encode the accepted level.
// - External lines 0-3 use register C nibbles; codes 0x600 to 0x660.
// - Lines 4-5 and port groups use register D; codes 0x680 to 0x720.
// - Transfer ends share E[15:12], codes 0x800-0x860, channel 0 ranks highest.
// - Infrared error, receive, break, transmit share E[11:8], codes 0x880-0x8E0.
// - FIFO serial error, receive, break, transmit share E[7:4], codes 0x900-0x960.
// - Converter end uses E[3:0] with secondary code 0x980.
// - Timer 0 and 1 underflows use A[15:12], A[11:8], codes 0x400, 0x420.
// - Timer 2 underflow and capture share A[7:4]; underflow ranks above capture.
// - Refresh compare-match and overflow share B[11:8]; compare-match ranks higher.
`ifndef IPE_DEFINES_VH
`define IPE_DEFINES_VH

// ----------------------------------------
// Register indices on the plain port
// ----------------------------------------
`define IPE_REG_A        3'h0
`define IPE_REG_B        3'h1
`define IPE_REG_C        3'h2
`define IPE_REG_D        3'h3
`define IPE_REG_E        3'h4
`define IPE_REG_PRI_CODE 3'h5
`define IPE_REG_SEC_CODE 3'h6
`define IPE_REG_STATUS   3'h7
`define IPE_PRIO_RESET   16'h0000

// ----------------------------------------
// Priority field positions
// ----------------------------------------
`define IPE_FLD_3  15:12
`define IPE_FLD_2  11:8
`define IPE_FLD_1  7:4
`define IPE_FLD_0  3:0

// ----------------------------------------
// Levels and event codes
// ----------------------------------------
`define IPE_LVL_NMI       5'h10
`define IPE_LVL_DEBUG     5'h0f
`define IPE_CODE_NMI      12'h1c0
`define IPE_CODE_DEBUG    12'h5e0
`define IPE_CODE_EXT      12'h600
`define IPE_CODE_PORT     12'h700
`define IPE_CODE_XFER     12'h800
`define IPE_CODE_TIMER    12'h400
`define IPE_CODE_LEVEL    12'h200
`define IPE_CODE_STEP     12'h020

// ----------------------------------------
// Source indices in default order
// ----------------------------------------
`define IPE_NUM_SRC   37
`define IPE_SRC_NMI   0
`define IPE_SRC_DBG   1
`define IPE_SRC_EXT0  2
`define IPE_SRC_PORT0 8
`define IPE_SRC_XFER0 10
`define IPE_SRC_ADC   22
`define IPE_SRC_TMR0  23

`endif

// ===== logic/ipe_prio_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "ipe_defines.vh"

module ipe_prio_regs (
	// Clock and reset
	input  wire        mclk_i,
	input  wire        srst_i,
	// Write port
	input  wire [2:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	// Register contents
	output reg  [15:0] prio_a_o,
	output reg  [15:0] prio_b_o,
	output reg  [15:0] prio_c_o,
	output reg  [15:0] prio_d_o,
	output reg  [15:0] prio_e_o
);

	// ----------------------------------------
	// Five priority registers
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (srst_i) begin
			prio_a_o <= `IPE_PRIO_RESET;
			prio_b_o <= `IPE_PRIO_RESET;
			prio_c_o <= `IPE_PRIO_RESET;
			prio_d_o <= `IPE_PRIO_RESET;
			prio_e_o <= `IPE_PRIO_RESET;
		end else if (wr_i) begin
			case (addr_i)
				`IPE_REG_A: prio_a_o <= wdata_i;
				`IPE_REG_B: prio_b_o <= wdata_i;
				`IPE_REG_C: prio_c_o <= wdata_i;
				`IPE_REG_D: prio_d_o <= wdata_i;
				`IPE_REG_E: prio_e_o <= wdata_i;
				default: begin
				end
			endcase
		end
	end

endmodule // ipe_prio_regs
`default_nettype wire

// ===== logic/ipe_encoder.v
`timescale 1ns/1ps
`default_nettype none
`include "ipe_defines.vh"

module ipe_encoder (
	// Clock and reset
	input  wire        mclk_i,
	input  wire        srst_i,
	// Register port
	input  wire [2:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	// Fixed-level sources
	input  wire        nmi_i,
	input  wire        debug_port_request_i,
	// External lines and port groups
	input  wire [5:0]  external_line_i,
	input  wire        port_group_low_i,
	input  wire        port_group_high_i,
	// Transfer engine, serial channels and converter
	input  wire [3:0]  transfer_end_i,
	input  wire        infrared_error_i,
	input  wire        infrared_receive_i,
	input  wire        infrared_break_i,
	input  wire        infrared_transmit_i,
	input  wire        fifo_serial_error_i,
	input  wire        fifo_serial_receive_i,
	input  wire        fifo_serial_break_i,
	input  wire        fifo_serial_transmit_i,
	input  wire        converter_end_i,
	// Timer unit and clock
	input  wire        timer0_underflow_i,
	input  wire        timer1_underflow_i,
	input  wire        timer2_underflow_i,
	input  wire        timer2_capture_i,
	input  wire        clock_alarm_i,
	input  wire        clock_periodic_i,
	input  wire        clock_carry_i,
	// Basic serial, watchdog and refresh
	input  wire        basic_serial_error_i,
	input  wire        basic_serial_receive_i,
	input  wire        basic_serial_transmit_i,
	input  wire        basic_serial_tx_end_i,
	input  wire        watchdog_interval_i,
	input  wire        refresh_compare_match_i,
	input  wire        refresh_overflow_i,
	// Core side
	input  wire [3:0]  core_mask_i,
	input  wire        core_accept_i,
	output reg         irq_req_o,
	output reg  [4:0]  irq_level_o,
	output reg  [11:0] primary_event_code_o,
	output reg  [11:0] secondary_event_code_o
);

	// ----------------------------------------
	// Priority registers
	// ----------------------------------------
	wire [15:0] prio_a;
	wire [15:0] prio_b;
	wire [15:0] prio_c;
	wire [15:0] prio_d;
	wire [15:0] prio_e;

	ipe_prio_regs u_regs (
		.mclk_i   (mclk_i),
		.srst_i   (srst_i),
		.addr_i   (addr_i),
		.wdata_i  (wdata_i),
		.wr_i     (wr_i),
		.prio_a_o (prio_a),
		.prio_b_o (prio_b),
		.prio_c_o (prio_c),
		.prio_d_o (prio_d),
		.prio_e_o (prio_e)
	);

	// ----------------------------------------
	// Pending vector, index 0 ranks first
	// ----------------------------------------
	wire [`IPE_NUM_SRC-1:0] req;

	assign req = {refresh_overflow_i, refresh_compare_match_i, watchdog_interval_i,
		basic_serial_tx_end_i, basic_serial_transmit_i, basic_serial_receive_i,
		basic_serial_error_i, clock_carry_i, clock_periodic_i, clock_alarm_i,
		timer2_capture_i, timer2_underflow_i, timer1_underflow_i, timer0_underflow_i,
		converter_end_i, fifo_serial_transmit_i, fifo_serial_break_i,
		fifo_serial_receive_i, fifo_serial_error_i, infrared_transmit_i,
		infrared_break_i, infrared_receive_i, infrared_error_i,
		transfer_end_i[3], transfer_end_i[2], transfer_end_i[1], transfer_end_i[0],
		port_group_high_i, port_group_low_i, external_line_i,
		debug_port_request_i, nmi_i};

	// ----------------------------------------
	// Level and code per source
	// ----------------------------------------
	function [4:0] lvl_of;
		input integer i;
		begin
			case (i)
				0:  lvl_of = `IPE_LVL_NMI;
				1:  lvl_of = `IPE_LVL_DEBUG;
				2:  lvl_of = {1'b0, prio_c[`IPE_FLD_0]};
				3:  lvl_of = {1'b0, prio_c[`IPE_FLD_1]};
				4:  lvl_of = {1'b0, prio_c[`IPE_FLD_2]};
				5:  lvl_of = {1'b0, prio_c[`IPE_FLD_3]};
				6:  lvl_of = {1'b0, prio_d[`IPE_FLD_0]};
				7:  lvl_of = {1'b0, prio_d[`IPE_FLD_1]};
				8:  lvl_of = {1'b0, prio_d[`IPE_FLD_3]};
				9:  lvl_of = {1'b0, prio_d[`IPE_FLD_2]};
				10, 11, 12, 13:
					lvl_of = {1'b0, prio_e[`IPE_FLD_3]};
				14, 15, 16, 17:
					lvl_of = {1'b0, prio_e[`IPE_FLD_2]};
				18, 19, 20, 21:
					lvl_of = {1'b0, prio_e[`IPE_FLD_1]};
				22: lvl_of = {1'b0, prio_e[`IPE_FLD_0]};
				23: lvl_of = {1'b0, prio_a[`IPE_FLD_3]};
				24: lvl_of = {1'b0, prio_a[`IPE_FLD_2]};
				25, 26:
					lvl_of = {1'b0, prio_a[`IPE_FLD_1]};
				27, 28, 29:
					lvl_of = {1'b0, prio_a[`IPE_FLD_0]};
				30, 31, 32, 33:
					lvl_of = {1'b0, prio_b[`IPE_FLD_1]};
				34: lvl_of = {1'b0, prio_b[`IPE_FLD_3]};
				35, 36:
					lvl_of = {1'b0, prio_b[`IPE_FLD_2]};
				default: lvl_of = 5'h00;
			endcase
		end
	endfunction

	// Codes run in steps inside each block, so one base per block suffices.
	function [11:0] sec_of;
		input integer i;
		reg [11:0] k;
		integer    j;
		begin
			k = 12'h000;
			j = 0;
			if (i == `IPE_SRC_NMI) begin
				sec_of = `IPE_CODE_NMI;
			end else if (i == `IPE_SRC_DBG) begin
				sec_of = `IPE_CODE_DEBUG;
			end else if (i < `IPE_SRC_PORT0) begin
				j = i - `IPE_SRC_EXT0;
				k = j[11:0];
				sec_of = `IPE_CODE_EXT + k * `IPE_CODE_STEP;
			end else if (i < `IPE_SRC_XFER0) begin
				j = i - `IPE_SRC_PORT0;
				k = j[11:0];
				sec_of = `IPE_CODE_PORT + k * `IPE_CODE_STEP;
			end else if (i < `IPE_SRC_TMR0) begin
				j = i - `IPE_SRC_XFER0;
				k = j[11:0];
				sec_of = `IPE_CODE_XFER + k * `IPE_CODE_STEP;
			end else begin
				j = i - `IPE_SRC_TMR0;
				k = j[11:0];
				sec_of = `IPE_CODE_TIMER + k * `IPE_CODE_STEP;
			end
		end
	endfunction

	// ----------------------------------------
	// Winner search
	// ----------------------------------------
	// A strict greater-than keeps the earliest source on a tie, which gives the
	// default order for free; level 0 never wins, as the search starts from best_lvl 0.
	reg [4:0]  best_lvl;
	reg [11:0] best_sec;
	reg [11:0] best_pri;
	reg [5:0]  best_idx;
	reg        best_vld;
	integer    n;

	// The levels are read inside functions, which an implicit list would miss, so the registers are named here.
	always @(req or prio_a or prio_b or prio_c or prio_d or prio_e) begin
		best_lvl = 5'h00;
		best_sec = 12'h000;
		best_idx = 6'h00;
		best_vld = 1'b0;
		for (n = 0; n < `IPE_NUM_SRC; n = n + 1) begin
			if (req[n] && (lvl_of(n) > best_lvl)) begin
				best_lvl = lvl_of(n);
				best_sec = sec_of(n);
				best_idx = n[5:0];
				best_vld = 1'b1;
			end
		end
		if (best_vld && (best_idx >= `IPE_SRC_EXT0) && (best_idx <= `IPE_SRC_ADC)) begin
			best_pri = `IPE_CODE_LEVEL + {7'h00, 5'h0f - best_lvl} * `IPE_CODE_STEP;
		end else begin
			best_pri = best_sec;
		end
	end

	// ----------------------------------------
	// Offer to the core
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (srst_i) begin
			irq_req_o     <= 1'b0;
			irq_level_o   <= 5'h00;
			primary_event_code_o   <= 12'h000;
			secondary_event_code_o <= 12'h000;
		end else begin
			irq_req_o   <= best_vld && (best_lvl > {1'b0, core_mask_i});
			irq_level_o <= best_lvl;
			primary_event_code_o   <= best_pri;
			secondary_event_code_o <= best_sec;
		end
	end

	// ----------------------------------------
	// Event registers latched on acceptance
	// ----------------------------------------
	// The latch takes the offer the core actually saw, not a fresher winner.
	reg [11:0] pri_code_q;
	reg [11:0] sec_code_q;
	reg        accepted_q;

	always @(posedge mclk_i) begin
		if (srst_i) begin
			pri_code_q <= 12'h000;
			sec_code_q <= 12'h000;
			accepted_q <= 1'b0;
		end else if (core_accept_i && irq_req_o) begin
			pri_code_q <= primary_event_code_o;
			sec_code_q <= secondary_event_code_o;
			accepted_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Read port, data one cycle after strobe
	// ----------------------------------------
	always @(posedge mclk_i) begin
		if (srst_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			case (addr_i)
				`IPE_REG_A:        rdata_o <= prio_a;
				`IPE_REG_B:        rdata_o <= prio_b;
				`IPE_REG_C:        rdata_o <= prio_c;
				`IPE_REG_D:        rdata_o <= prio_d;
				`IPE_REG_E:        rdata_o <= prio_e;
				`IPE_REG_PRI_CODE: rdata_o <= {4'h0, pri_code_q};
				`IPE_REG_SEC_CODE: rdata_o <= {4'h0, sec_code_q};
				`IPE_REG_STATUS:   rdata_o <= {accepted_q, irq_req_o, 3'h0, best_idx, irq_level_o};
				default:           rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

endmodule // ipe_encoder
`default_nettype wire

// ===== verif/ipe_encoder_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ipe_encoder_asserts (
	// Clock and reset
	input wire logic        mclk_i,
	input wire logic        srst_i,
	// Register port
	input wire logic [2:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	// Sources and core side
	input wire logic        nmi_i,
	input wire logic        debug_port_request_i,
	input wire logic [3:0]  core_mask_i,
	input wire logic        irq_req_o,
	input wire logic [4:0]  irq_level_o,
	input wire logic [11:0] primary_event_code_o,
	input wire logic [11:0] secondary_event_code_o
);
	// --------------------
	// Offer and read port checks
	// --------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	a_nmi_wins: assert property (
		nmi_i |=> irq_level_o == 5'h10 && primary_event_code_o == 12'h1c0 && secondary_event_code_o == 12'h1c0)
		else $error("nmi offer wrong");
	a_debug_fixed: assert property (
		debug_port_request_i && !nmi_i |=> irq_level_o == 5'h0f && primary_event_code_o == 12'h5e0
		&& secondary_event_code_o == 12'h5e0) else $error("debug offer wrong");
	a_mask_gate: assert property (
		irq_req_o == (irq_level_o > {1'b0, $past(core_mask_i)})) else $error("mask gating wrong");
	a_idle_none: assert property (
		irq_level_o == 5'h00 |-> !irq_req_o && primary_event_code_o == 12'h000 && secondary_event_code_o == 12'h000)
		else $error("idle offer not clear");
	a_level_code: assert property (
		irq_level_o != 5'h00 && secondary_event_code_o >= 12'h600 |->
		primary_event_code_o == 12'h200 + (12'h00f - {7'h00, irq_level_o}) * 12'h020) else $error("level code wrong");
	a_direct_code: assert property (
		secondary_event_code_o < 12'h600 |-> primary_event_code_o == secondary_event_code_o)
		else $error("direct code differs");
	a_read_back: assert property (
		(wr_i && addr_i < 3'h5) ##1 !wr_i ##1 (rd_i && addr_i == $past(addr_i, 2)) |=> rdata_o == $past(wdata_i, 3))
		else $error("priority read back wrong");
	a_code_upper: assert property (
		rd_i && (addr_i == 3'h5 || addr_i == 3'h6) |=> rdata_o[15:12] == 4'h0) else $error("code upper bits set");
endmodule // ipe_encoder_asserts
bind ipe_encoder ipe_encoder_asserts i_chk (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .nmi_i,
	.debug_port_request_i, .core_mask_i, .irq_req_o, .irq_level_o, .primary_event_code_o, .secondary_event_code_o);
`default_nettype wire

// ===== verif/ipe_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipe_core_model (
	// Clock and reset
	input  wire logic mclk_i,
	input  wire logic srst_i,
	// Offer and control
	input  wire logic irq_req_i,
	input  wire logic take_i,
	output var  logic core_accept_o
);
	// --------------------
	// Accept
	// --------------------
	// No pulse in two cycles running, and only on a standing offer, so an offer is never taken in back-to-back cycles.
	always @(posedge mclk_i) begin
		core_accept_o <= !srst_i && take_i && irq_req_i && !core_accept_o;
	end
endmodule // ipe_core_model
`default_nettype wire

// ===== verif/irq_mode_priority_encoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module irq_mode_priority_encoder_tb;
	// --------------------
	// Signals
	// --------------------
	logic        mclk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        wr_i = 1'b0, rd_i = 1'b0, take = 1'b0;
	logic [2:0]  addr_i = 3'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic [3:0]  core_mask_i = 4'h0;
	logic [36:0] src = 37'h0;
	wire logic        accept, irq_req_o;
	wire logic [4:0]  lvl;
	wire logic [11:0] pc, sc;
	wire logic [15:0] rdata_o;
	int          error_cnt = 0;
	int          samples_checked = 0;
	logic [15:0] d;
	always #25 mclk_i = ~mclk_i;
	ipe_encoder i_dut (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .nmi_i(src[0]),
		.debug_port_request_i(src[1]), .external_line_i(src[7:2]), .port_group_low_i(src[8]),
		.port_group_high_i(src[9]), .transfer_end_i(src[13:10]), .infrared_error_i(src[14]),
		.infrared_receive_i(src[15]), .infrared_break_i(src[16]), .infrared_transmit_i(src[17]),
		.fifo_serial_error_i(src[18]), .fifo_serial_receive_i(src[19]), .fifo_serial_break_i(src[20]),
		.fifo_serial_transmit_i(src[21]), .converter_end_i(src[22]), .timer0_underflow_i(src[23]),
		.timer1_underflow_i(src[24]), .timer2_underflow_i(src[25]), .timer2_capture_i(src[26]),
		.clock_alarm_i(src[27]), .clock_periodic_i(src[28]), .clock_carry_i(src[29]),
		.basic_serial_error_i(src[30]), .basic_serial_receive_i(src[31]), .basic_serial_transmit_i(src[32]),
		.basic_serial_tx_end_i(src[33]), .watchdog_interval_i(src[34]), .refresh_compare_match_i(src[35]),
		.refresh_overflow_i(src[36]), .core_mask_i, .core_accept_i(accept), .irq_req_o, .irq_level_o(lvl),
		.primary_event_code_o(pc), .secondary_event_code_o(sc));
	ipe_core_model i_core (.mclk_i, .srst_i, .irq_req_i(irq_req_o), .take_i(take), .core_accept_o(accept));
	// --------------------
	// Helpers
	// --------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask
	task automatic set_src(input logic [36:0] v, input logic [3:0] m);
		@(posedge mclk_i);
		src <= v;
		core_mask_i <= m;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	// Field of source i as register index times four plus nibble.
	function automatic int fld(int i);
		return i < 6 ? 6 + i : i == 6 ? 12 : i == 7 ? 13 : i == 8 ? 15 : i == 9 ? 14 : i < 14 ? 19 : i < 18 ? 18 :
			i < 22 ? 17 : i == 22 ? 16 : i == 23 ? 3 : i == 24 ? 2 : i < 27 ? 1 : i < 30 ? 0 : i < 34 ? 5 :
			i == 34 ? 7 : 6;
	endfunction
	function automatic int code(int i);
		return i < 8 ? 12'h600 + 32 * (i - 2) : i < 10 ? 12'h700 + 32 * (i - 8) :
			i < 23 ? 12'h800 + 32 * (i - 10) : 12'h400 + 32 * (i - 23);
	endfunction
	// --------------------
	// Scenarios
	// --------------------
	task automatic t_regs;
		for (int a = 0; a < 5; a++) begin
			rd_reg(3'(a));
			chk(d, 16'h0000);
			wr_reg(3'(a), 16'ha5c3 ^ 16'(a));
			rd_reg(3'(a));
			chk(d, 16'ha5c3 ^ 16'(a));
		end
		wr_reg(3'h5, 16'hffff);
		rd_reg(3'h5);
		chk(d, 16'h0000);
	endtask
	// Whole-register writes clear the neighbouring fields; only one source is raised, so that is harmless.
	task automatic t_single;
		int l, w;
		for (int i = 2; i < 37; i++) begin
			l = i % 15 + 1;
			w = fld(i);
			wr_reg(3'(w / 4), 16'(l << (4 * (w % 4))));
			set_src(37'h1 << i, 4'(l - 1));
			chk(irq_req_o, 16'h0001);
			chk(lvl, 16'(l));
			chk(sc, 16'(code(i)));
			chk(pc, i < 23 ? 16'(12'h200 + 32 * (15 - l)) : 16'(code(i)));
			set_src(37'h1 << i, 4'(l));
			chk(irq_req_o, 16'h0000);
		end
	endtask
	task automatic t_fixed_order;
		logic [36:0] v;
		set_src(37'h3, 4'hf);
		chk(irq_req_o, 16'h0001);
		chk(lvl, 16'h0010);
		chk(pc, 16'h01c0);
		chk(sc, 16'h01c0);
		for (int a = 0; a < 5; a++) wr_reg(3'(a), 16'h5555);
		v = 37'h1f_ffff_fffc;
		set_src(v | 37'h2, 4'he);
		chk(lvl, 16'h000f);
		chk(pc, 16'h05e0);
		chk(sc, 16'h05e0);
		for (int i = 2; i < 37; i++) begin
			set_src(v, 4'h0);
			chk(sc, 16'(code(i)));
			chk(lvl, 16'h0005);
			v[i] = 1'b0;
		end
	endtask
	task automatic t_accept;
		wr_reg(3'h2, 16'h0003);
		set_src(37'h4, 4'h2);
		@(posedge mclk_i);
		take <= 1'b1;
		@(posedge mclk_i);
		take <= 1'b0;
		rd_reg(3'h6);
		chk(d, 16'h0600);
		rd_reg(3'h5);
		chk(d, 16'h0380);
		rd_reg(3'h7);
		chk(d, 16'hc043);
		// A reset in mid-run must clear the levels and the latched state again.
		@(posedge mclk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		srst_i <= 1'b0;
		rd_reg(3'h2);
		chk(d, 16'h0000);
		rd_reg(3'h7);
		chk(d, 16'h0000);
		chk(lvl, 16'h0000);
	endtask
	// --------------------
	// Run
	// --------------------
	task automatic summarize;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#1_000_000;
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge mclk_i);
		srst_i <= 1'b0;
		t_regs();
		t_single();
		t_fixed_order();
		t_accept();
		summarize();
	end
endmodule // irq_mode_priority_encoder_tb
`default_nettype wire
